// ---- hw/ussf_idle_det.sv ----
// Purpose: Counts consecutive ones on the receive line
// Assumes: i_bit_tick marks one sample per bit time
// Notes: Fires once per idle stretch, rearmed by a zero
`timescale 1ns/1ns
`default_nettype none
module ussf_idle_det (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Line
	input wire logic i_bit_tick,
	input wire logic i_rx_bit,
	input wire logic [3:0] i_target,
	// Result
	output logic o_idle
);
	logic [3:0] cnt_r; // Ones seen so far
	logic fired_r; // Already reported this stretch

	// Count ones; saturate once reported so it fires only once
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt_r <= 4'h0;
			fired_r <= 1'b0;
			o_idle <= 1'b0;
		end
		else if (i_ce)
		begin
			o_idle <= 1'b0;
			if (i_bit_tick)
			begin
				if (!i_rx_bit)
				begin
					cnt_r <= 4'h0;
					fired_r <= 1'b0;
				end
				else if (!fired_r && (cnt_r + 4'h1 == i_target))
				begin
					o_idle <= 1'b1;
					fired_r <= 1'b1;
				end
				else if (!fired_r)
				begin
					cnt_r <= cnt_r + 4'h1;
				end
			end
		end
	end

	// A frozen clock enable holds the pulse, so only enabled cycles count
	AST_IDLE_SINGLE: assert property (@(posedge i_clk)
		disable iff (i_srst) (o_idle && i_ce) |=> !o_idle)
		else $error("idle pulse longer than one cycle");
endmodule : ussf_idle_det
`default_nettype wire

// ---- hw/ussf_status.sv ----
// Purpose: Status flag logic of an asynchronous serial interface
// Assumes: Datapath supplies one-cycle event strobes; Wishbone classic
// Notes: Flags clear by status read then data-low access
`timescale 1ns/1ns
`default_nettype none
module ussf_status #(
	parameter int DATA_W = 8 // Frame data width
) (
	// Clock, reset, enable
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire logic I_CE,
	// Wishbone classic slave
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// Transmit datapath
	input wire logic I_TX_LOAD,
	input wire logic I_TX_BUSY,
	input wire logic I_TX_QUEUE,
	output logic [8:0] O_TX_DATA,
	output logic O_TX_DATA_VALID,
	// Receive datapath
	input wire logic I_RX_DONE,
	input wire logic [8:0] I_RX_DATA,
	input wire logic I_RX_NOISE,
	input wire logic I_RX_STOP_BIT,
	input wire logic I_RX_PARITY_BIT,
	input wire logic I_RX_WAKE,
	input wire logic I_BIT_TICK,
	input wire logic I_RX_LINE,
	output logic O_RX_ACCEPT,
	// Interrupt requests
	output logic O_IRQ_TX,
	output logic O_IRQ_RX
);
	logic [7:0] status_r; // Flag bits
	logic [7:0] status_nxt;
	logic [7:0] seen_r; // Flags shown by last status read
	logic [7:0] ctrl_r; // Enables and format
	logic [8:0] rx_data_r; // Receive holding register
	logic idle_armed_r; // Idle allowed to set again
	logic idle_hit; // Idle detector pulse
	logic acc; // Bus access this cycle
	logic rd_status;
	logic rd_data;
	logic wr_data;
	logic wr_ctrl;
	logic wr_high;
	logic frame_ok; // Frame lands in holding register
	logic frame_over; // Frame causes overrun
	logic par_bad;
	logic [7:0] clr_rd; // Flags cleared by this data read
	logic [7:0] clr_wr; // Flags cleared by this data write

	// Parity of data bits against selected type
	function automatic logic parity_calc(input logic [8:0] d, input logic nine, input logic odd);
		logic p;
		p = nine ? ^d : ^d[7:0];
		parity_calc = p ^ odd;
	endfunction : parity_calc

	// Decode one access per request; ack pulses for one cycle
	assign acc = I_WB_CYC && I_WB_STB && !O_WB_ACK && I_CE;
	assign rd_status = acc && !I_WB_WE && I_WB_ADR == ussf_pkg::ADDR_STATUS;
	assign rd_data = acc && !I_WB_WE && I_WB_ADR == ussf_pkg::ADDR_DATA_LOW;
	assign wr_data = acc && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == ussf_pkg::ADDR_DATA_LOW;
	assign wr_ctrl = acc && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == ussf_pkg::ADDR_CONTROL;
	assign wr_high = acc && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == ussf_pkg::ADDR_DATA_HIGH;

	// Framing error holds off reception until cleared
	assign frame_ok = I_RX_DONE && !status_r[ussf_pkg::BIT_FRAMING]
		&& !status_r[ussf_pkg::BIT_RX_FULL];
	assign frame_over = I_RX_DONE && !status_r[ussf_pkg::BIT_FRAMING]
		&& status_r[ussf_pkg::BIT_RX_FULL];
	assign par_bad = ctrl_r[ussf_pkg::CTL_PARITY_EN] && (parity_calc(I_RX_DATA,
		ctrl_r[ussf_pkg::CTL_NINE_BIT], ctrl_r[ussf_pkg::CTL_PARITY_TYPE]) != I_RX_PARITY_BIT);

	// Only flags seen in the prior status read may clear
	assign clr_rd = rd_data ? (seen_r & 8'h3F) : 8'h00;
	assign clr_wr = wr_data ? (seen_r & 8'hC0) : 8'h00;

	// Idle detector for the receive line
	ussf_idle_det u_idle (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_ce(I_CE),
		.i_bit_tick(I_BIT_TICK),
		.i_rx_bit(I_RX_LINE),
		.i_target(ctrl_r[ussf_pkg::CTL_NINE_BIT] ? ussf_pkg::IDLE_BITS_9
			: ussf_pkg::IDLE_BITS_8),
		.o_idle(idle_hit)
	);

	// Next flag values; sets beat clears except tx complete
	always_comb
	begin
		status_nxt = status_r & ~clr_rd & ~clr_wr;
		if (I_TX_LOAD)
		begin
			status_nxt[ussf_pkg::BIT_TX_EMPTY] = 1'b1;
		end
		if (I_TX_BUSY || I_TX_QUEUE || clr_wr[ussf_pkg::BIT_TX_COMPLETE])
		begin
			status_nxt[ussf_pkg::BIT_TX_COMPLETE] = 1'b0;
		end
		else if (status_nxt[ussf_pkg::BIT_TX_EMPTY])
		begin
			status_nxt[ussf_pkg::BIT_TX_COMPLETE] = 1'b1;
		end
		if (frame_ok)
		begin
			status_nxt[ussf_pkg::BIT_RX_FULL] = 1'b1;
			status_nxt[ussf_pkg::BIT_NOISE] = I_RX_NOISE;
			status_nxt[ussf_pkg::BIT_FRAMING] = !I_RX_STOP_BIT;
			status_nxt[ussf_pkg::BIT_PARITY] = par_bad;
		end
		if (frame_over)
		begin
			status_nxt[ussf_pkg::BIT_OVERRUN] = 1'b1;
		end
		if (idle_hit && idle_armed_r && !ctrl_r[ussf_pkg::CTL_WAKEUP])
		begin
			status_nxt[ussf_pkg::BIT_IDLE] = 1'b1;
		end
	end

	// Flag register; status writes have no path here
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			status_r <= ussf_pkg::STATUS_RESET;
		end
		else if (I_CE)
		begin
			status_r <= status_nxt;
		end
	end

	// Snapshot of flags on status read; consumed by data access
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			seen_r <= 8'h00;
		end
		else if (rd_status)
		begin
			seen_r <= status_r;
		end
		else if (rd_data || wr_data)
		begin
			seen_r <= seen_r & ~(clr_rd | clr_wr);
		end
	end

	// Idle rearm: cleared idle waits for a good frame
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			idle_armed_r <= 1'b1;
		end
		else if (I_CE)
		begin
			if (frame_ok)
			begin
				idle_armed_r <= 1'b1;
			end
			else if (clr_rd[ussf_pkg::BIT_IDLE] || status_nxt[ussf_pkg::BIT_IDLE])
			begin
				idle_armed_r <= 1'b0;
			end
		end
	end

	// Control register; hardware wake clears the wakeup bit
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			ctrl_r <= ussf_pkg::CONTROL_RESET;
		end
		else if (I_CE)
		begin
			if (wr_ctrl)
			begin
				ctrl_r <= I_WB_DAT[7:0];
			end
			else if (I_RX_WAKE)
			begin
				ctrl_r[ussf_pkg::CTL_WAKEUP] <= 1'b0;
			end
		end
	end

	// Receive holding register keeps old data on overrun
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			rx_data_r <= 9'h000;
		end
		else if (I_CE && frame_ok)
		begin
			rx_data_r <= I_RX_DATA;
		end
	end

	// Transmit data; high byte first, low byte launches
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			O_TX_DATA <= 9'h000;
			O_TX_DATA_VALID <= 1'b0;
		end
		else if (I_CE)
		begin
			if (wr_high)
			begin
				O_TX_DATA[8] <= I_WB_DAT[6];
			end
			if (wr_data)
			begin
				O_TX_DATA[7:0] <= I_WB_DAT[7:0];
				O_TX_DATA_VALID <= 1'b1;
			end
			else if (I_TX_LOAD)
			begin
				O_TX_DATA_VALID <= 1'b0;
			end
		end
	end

	// Bus answer: one registered ack a cycle after the request, unmapped reads return zero
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h0000_0000;
		end
		else if (I_CE)
		begin
			O_WB_ACK <= acc;
			O_WB_DAT <= 32'h0000_0000;
			if (acc && !I_WB_WE)
			begin
				case (I_WB_ADR)
					ussf_pkg::ADDR_STATUS: O_WB_DAT <= {24'h000000, status_r};
					ussf_pkg::ADDR_DATA_LOW: O_WB_DAT <= {24'h000000, rx_data_r[7:0]};
					ussf_pkg::ADDR_CONTROL: O_WB_DAT <= {24'h000000, ctrl_r};
					ussf_pkg::ADDR_DATA_HIGH: O_WB_DAT <= {24'h000000, rx_data_r[8],
						O_TX_DATA[8], 6'h00};
					default: O_WB_DAT <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Interrupts and accept output, registered
	always_ff @(posedge I_CLK)
	begin
		if (I_SRST)
		begin
			O_IRQ_TX <= 1'b0;
			O_IRQ_RX <= 1'b0;
			O_RX_ACCEPT <= 1'b1;
		end
		else if (I_CE)
		begin
			O_IRQ_TX <= (status_nxt[ussf_pkg::BIT_TX_EMPTY] && ctrl_r[ussf_pkg::CTL_TX_EMPTY_IE])
				|| (status_nxt[ussf_pkg::BIT_TX_COMPLETE]
				&& ctrl_r[ussf_pkg::CTL_TX_COMPLETE_IE]);
			O_IRQ_RX <= !ctrl_r[ussf_pkg::CTL_WAKEUP] && (((status_nxt[ussf_pkg::BIT_RX_FULL]
				|| status_nxt[ussf_pkg::BIT_OVERRUN]) && ctrl_r[ussf_pkg::CTL_RX_FULL_IE])
				|| (status_nxt[ussf_pkg::BIT_IDLE]
				&& ctrl_r[ussf_pkg::CTL_IDLE_IE]));
			O_RX_ACCEPT <= !status_nxt[ussf_pkg::BIT_FRAMING];
		end
	end

	// Checks next to the flag logic
	AST_CLEAR_NEEDS_SEEN: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		(I_CE && rd_data && !seen_r[ussf_pkg::BIT_RX_FULL] && !frame_ok)
		|=> status_r[ussf_pkg::BIT_RX_FULL] == $past(status_r[ussf_pkg::BIT_RX_FULL]))
		else $error("rx full cleared without status read");
	// Tx complete may still settle after busy drops, so it is left out
	AST_STATUS_WRITE_IGNORED: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		(acc && I_WB_WE && I_WB_ADR == ussf_pkg::ADDR_STATUS && !I_RX_DONE && !I_TX_LOAD
		&& !I_TX_BUSY && !I_TX_QUEUE && !idle_hit)
		|=> (status_r & 8'hBF) == ($past(status_r) & 8'hBF))
		else $error("status write changed flags");
	AST_TX_EMPTY_SET: assert property (@(posedge I_CLK)
		disable iff (I_SRST) (I_CE && I_TX_LOAD) |=> status_r[ussf_pkg::BIT_TX_EMPTY])
		else $error("tx empty not set on load");
	AST_TC_CLEAR_WINS: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		(I_CE && (I_TX_QUEUE || I_TX_BUSY)) |=> !status_r[ussf_pkg::BIT_TX_COMPLETE])
		else $error("tx complete set while busy");
	AST_RX_FULL_SET: assert property (@(posedge I_CLK)
		disable iff (I_SRST) (I_CE && frame_ok) |=> status_r[ussf_pkg::BIT_RX_FULL]
		&& rx_data_r == $past(I_RX_DATA))
		else $error("rx full or data not loaded");
	AST_OVERRUN_KEEPS: assert property (@(posedge I_CLK)
		disable iff (I_SRST) (I_CE && frame_over) |=> status_r[ussf_pkg::BIT_OVERRUN]
		&& $stable(rx_data_r))
		else $error("overrun mishandled");
	AST_WAKE_NO_IDLE: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		(I_CE && ctrl_r[ussf_pkg::CTL_WAKEUP] && !status_r[ussf_pkg::BIT_IDLE])
		|=> !status_r[ussf_pkg::BIT_IDLE])
		else $error("idle set in wakeup standby");
	// A frame during a framing error leaves data and the accept pin alone
	AST_FE_BLOCKS: assert property (@(posedge I_CLK)
		disable iff (I_SRST)
		(I_CE && status_r[ussf_pkg::BIT_FRAMING] && I_RX_DONE && !rd_data)
		|=> $stable(rx_data_r) && !O_RX_ACCEPT)
		else $error("frame accepted during framing error");
	AST_ACK_ONE: assert property (@(posedge I_CLK)
		disable iff (I_SRST) (O_WB_ACK && I_CE) |=> !O_WB_ACK)
		else $error("ack held two cycles");
	COV_RX_CLEAR: cover property (@(posedge I_CLK) disable iff (I_SRST)
		rd_status ##[1:20] (rd_data && seen_r[ussf_pkg::BIT_RX_FULL]));
	COV_OVERRUN: cover property (@(posedge I_CLK) disable iff (I_SRST) frame_over);
	COV_IDLE: cover property (@(posedge I_CLK) disable iff (I_SRST)
		status_nxt[ussf_pkg::BIT_IDLE] && !status_r[ussf_pkg::BIT_IDLE]);
endmodule : ussf_status
`default_nettype wire

// ---- include/ussf_pkg.sv ----
// Purpose: Shared constants for the serial status flag block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Flag bit positions follow the status register layout
package ussf_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA_LOW = 8'h04;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_DATA_HIGH = 8'h0C;
	// Status bit positions
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_TX_COMPLETE = 6;
	localparam int BIT_RX_FULL = 5;
	localparam int BIT_IDLE = 4;
	localparam int BIT_OVERRUN = 3;
	localparam int BIT_NOISE = 2;
	localparam int BIT_FRAMING = 1;
	localparam int BIT_PARITY = 0;
	// Control bit positions
	localparam int CTL_TX_EMPTY_IE = 7;
	localparam int CTL_TX_COMPLETE_IE = 6;
	localparam int CTL_RX_FULL_IE = 5;
	localparam int CTL_IDLE_IE = 4;
	localparam int CTL_NINE_BIT = 3;
	localparam int CTL_PARITY_EN = 2;
	localparam int CTL_WAKEUP = 1;
	localparam int CTL_PARITY_TYPE = 0;
	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'hC0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// Idle line lengths in bit times
	localparam logic [3:0] IDLE_BITS_8 = 4'hA;
	localparam logic [3:0] IDLE_BITS_9 = 4'hB;
endpackage : ussf_pkg

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the serial status flag block
// Assumes: Wishbone classic master, datapath stand-in as partner
// Notes: Interrupt, accept and transmit pins are looked at on the falling edge, clear of updates
`timescale 1ns/1ns
`default_nettype none
module tb;
	// Register offsets, shortened
	localparam logic [7:0] ST = ussf_pkg::ADDR_STATUS;
	localparam logic [7:0] DL = ussf_pkg::ADDR_DATA_LOW;
	localparam logic [7:0] CT = ussf_pkg::ADDR_CONTROL;
	// Bench state
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, txv, load, busy, done, noise, stop, par, wake, tick, line;
	logic acc, irq_tx, irq_rx;
	logic [8:0] txd, rxd;
	logic [7:0] ctl [3] = '{8'h10, 8'h18, 8'h12};
	int mismatches = 0;
	int checks_done = 0;
	// Clock at 20 MHz
	initial
	begin
		forever #25 clk = ~clk;
	end
	// Block under test, queue event tied to the shift load
	ussf_status #(.DATA_W(8)) dut (.I_CLK(clk), .I_SRST(srst), .I_CE(ce),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
		.I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_TX_LOAD(load), .I_TX_BUSY(busy), .I_TX_QUEUE(load), .O_TX_DATA(txd),
		.O_TX_DATA_VALID(txv), .I_RX_DONE(done), .I_RX_DATA(rxd),
		.I_RX_NOISE(noise), .I_RX_STOP_BIT(stop), .I_RX_PARITY_BIT(par),
		.I_RX_WAKE(wake), .I_BIT_TICK(tick), .I_RX_LINE(line),
		.O_RX_ACCEPT(acc), .O_IRQ_TX(irq_tx), .O_IRQ_RX(irq_rx));
	// Far side of the datapath
	ussf_peer peer (.i_clk(clk), .i_tx_valid(txv), .o_load(load), .o_busy(busy),
		.o_done(done), .o_data(rxd), .o_noise(noise), .o_stop(stop), .o_par(par),
		.o_wake(wake), .o_tick(tick), .o_line(line));
	// Verdict and end of run
	task summarize;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One classic cycle; ack and read data are taken at the same rising edge
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
		begin
			mismatches++;
			summarize();
		end
		r = rdat;
		{cyc, stb, we} <= 3'h0;
		@(negedge clk);
	endtask : wb
	// Register read with expectation
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		// Reset value, status writes have no effect, unmapped reads zero
		rd(ST, 32'hC0);
		wb(1'b1, ST, 32'h0, q);
		rd(ST, 32'hC0);
		rd(8'h10, 32'h0);
		// Transmit: empty and complete clear, then set by the shifter
		wb(1'b1, CT, 32'h80, q);
		chk({31'h0, irq_tx}, 32'h1);
		wb(1'b1, ussf_pkg::ADDR_DATA_HIGH, 32'h40, q);
		rd(ST, 32'hC0);
		wb(1'b1, DL, 32'h55, q);
		chk({23'h0, txd}, 32'h155);
		chk({31'h0, txv}, 32'h1);
		rd(ST, 32'h00);
		chk({31'h0, irq_tx}, 32'h0);
		repeat (6) @(posedge clk);
		rd(ST, 32'h80);
		chk({31'h0, txv}, 32'h0);
		repeat (20) @(posedge clk);
		rd(ST, 32'hC0);
		// Receive: a flag set after the status read survives
		wb(1'b1, CT, 32'h20, q);
		rd(ST, 32'hC0);
		peer.send_frame(9'h03C, 1'b0, 1'b1, 1'b0);
		rd(DL, 32'h3C);
		rd(ST, 32'hE0);
		chk({31'h0, irq_rx}, 32'h1);
		// Overrun keeps old data and outlives receive-full
		peer.send_frame(9'h099, 1'b0, 1'b1, 1'b0);
		rd(DL, 32'h3C);
		rd(ST, 32'hC8);
		chk({31'h0, irq_rx}, 32'h1);
		rd(DL, 32'h3C);
		rd(ST, 32'hC0);
		// Noise, framing and parity errors; reception halted meanwhile
		wb(1'b1, CT, 32'h24, q);
		peer.send_frame(9'h001, 1'b1, 1'b0, 1'b0);
		rd(ST, 32'hE7);
		chk({31'h0, acc}, 32'h0);
		peer.send_frame(9'h0AA, 1'b0, 1'b1, 1'b0);
		rd(DL, 32'h01);
		rd(ST, 32'hC0);
		chk({31'h0, acc}, 32'h1);
		peer.send_frame(9'h003, 1'b0, 1'b1, 1'b0);
		rd(ST, 32'hE0);
		rd(DL, 32'h03);
		// Clock enable low: a frame in that time leaves no trace
		@(posedge clk);
		ce <= 1'b0;
		peer.send_frame(9'h0F0, 1'b0, 1'b1, 1'b0);
		ce <= 1'b1;
		rd(ST, 32'hC0);
		rd(DL, 32'h03);
		// Idle: eight-bit, nine-bit, then blocked by the wakeup bit
		for (int k = 0; k < 3; k++)
		begin
			// Clear leftovers first so the frame below rearms idle
			wb(1'b0, ST, 32'h0, q);
			wb(1'b0, DL, 32'h0, q);
			peer.send_frame(9'h05A, 1'b0, 1'b1, 1'b0);
			wb(1'b1, CT, {24'h0, ctl[k]}, q);
			peer.send_bits(1'b0, 1);
			peer.send_bits(1'b1, (k == 1) ? 10 : 9);
			wb(1'b0, ST, 32'h0, q);
			chk({31'h0, q[4]}, 32'h0);
			peer.send_bits(1'b1, 1);
			wb(1'b0, ST, 32'h0, q);
			chk({31'h0, q[4]}, {31'h0, k != 2});
			if (k == 0)
			begin
				// Cleared idle stays low without a new frame
				wb(1'b0, DL, 32'h0, q);
				peer.send_bits(1'b0, 1);
				peer.send_bits(1'b1, 12);
				wb(1'b0, ST, 32'h0, q);
				chk({31'h0, q[4]}, 32'h0);
			end
		end
		// Hardware wake drops the wakeup bit only
		peer.pulse_wake();
		rd(CT, 32'h10);
		summarize();
	end
endmodule : tb
`default_nettype wire

// ---- test/ussf_peer.sv ----
// Purpose: Serial datapath stand-in facing the status flag block
// Assumes: Frames and line bits are requested by the bench through tasks
// Notes: Frame qualifiers show inverted values once the strobe is gone
`timescale 1ns/1ns
`default_nettype none
module ussf_peer (
	// Clock and transmit request
	input wire logic i_clk,
	input wire logic i_tx_valid,
	// Transmit events
	output logic o_load,
	output logic o_busy,
	// Receive events
	output logic o_done,
	output logic [8:0] o_data,
	output logic o_noise,
	output logic o_stop,
	output logic o_par,
	output logic o_wake,
	output logic o_tick,
	output logic o_line
);
	// Late load, so the empty window can be read
	localparam int LOAD_DLY = 8;
	localparam int BUSY_LEN = 20;
	// Shifter: takes pending data, then sends for a while
	initial
	begin
		{o_load, o_busy, o_done, o_noise, o_wake, o_tick} = 6'h00;
		{o_data, o_stop, o_par, o_line} = 12'hFF9;
		forever
		begin
			// Sampled mid-cycle to stay clear of the update edge
			@(negedge i_clk);
			if (i_tx_valid === 1'b1)
			begin
				repeat (LOAD_DLY) @(posedge i_clk);
				o_load <= 1'b1;
				o_busy <= 1'b1;
				@(posedge i_clk);
				o_load <= 1'b0;
				repeat (BUSY_LEN) @(posedge i_clk);
				o_busy <= 1'b0;
			end
		end
	end
	// One finished frame with its qualifiers
	task send_frame(input logic [8:0] d, input logic n, input logic s, input logic p);
		@(posedge i_clk);
		o_done <= 1'b1;
		{o_data, o_noise, o_stop, o_par} <= {d, n, s, p};
		@(posedge i_clk);
		o_done <= 1'b0;
		{o_data, o_noise, o_stop, o_par} <= ~{d, n, s, p};
		@(posedge i_clk);
	endtask : send_frame
	// A run of bit samples at one level
	task send_bits(input logic v, input int cnt);
		repeat (cnt)
		begin
			@(posedge i_clk);
			o_tick <= 1'b1;
			o_line <= v;
			@(posedge i_clk);
			o_tick <= 1'b0;
		end
		@(posedge i_clk);
	endtask : send_bits
	// Wake event from address match logic
	task pulse_wake;
		@(posedge i_clk);
		o_wake <= 1'b1;
		@(posedge i_clk);
		o_wake <= 1'b0;
		@(posedge i_clk);
	endtask : pulse_wake
endmodule : ussf_peer
`default_nettype wire
